// [logic/i2c_index_block_target.sv]
`timescale 1ns/10ps
`include "i2c_index_regs.svh"

module i2c_index_block_target
  import i2c_index_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic [`REG_COUNT*8-1:0] cfg_bytes,
  output logic xfer_busy,
  output logic reg_wr_stb,
  output logic [`REG_IDX_W-1:0] reg_wr_idx,
  output logic [7:0] reg_wr_data
);

  tgt_s st_ff;
  tgt_s nxt_st;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic [7:0] next_rd_byte;

  // address select lives in the general control byte, so a write to it
  // takes effect from the next address phase
  function automatic logic [6:0] dev_addr(input logic [7:0] ctrl);
    dev_addr = `DEV_ADDR_BASE | {5'h00, ctrl[`ADDR_SEL_HI:`ADDR_SEL_LO]};
  endfunction

  function automatic logic [7:0] byte_at(input reg_bytes_t regs, input logic [7:0] idx);
    byte_at = regs[idx[`REG_IDX_W-1:0]];
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_stb = 1'b0;

    // three-stage sampling; a level counts once stages two and three agree,
    // which leaves many clk cycles per bit even at the fastest bus rate
    nxt_st.scl_s1 = scl_i;
    nxt_st.scl_s2 = st_ff.scl_s1;
    nxt_st.scl_s3 = st_ff.scl_s2;
    nxt_st.sda_s1 = sda_i;
    nxt_st.sda_s2 = st_ff.sda_s1;
    nxt_st.sda_s3 = st_ff.sda_s2;
    if (st_ff.scl_s2 == st_ff.scl_s3) begin
      nxt_st.scl_f = st_ff.scl_s3;
    end
    if (st_ff.sda_s2 == st_ff.sda_s3) begin
      nxt_st.sda_f = st_ff.sda_s3;
    end

    scl_rise = nxt_st.scl_f & ~st_ff.scl_f;
    scl_fall = ~nxt_st.scl_f & st_ff.scl_f;
    start_seen = st_ff.scl_f & nxt_st.scl_f & st_ff.sda_f & ~nxt_st.sda_f;
    stop_seen = st_ff.scl_f & nxt_st.scl_f & ~st_ff.sda_f & nxt_st.sda_f;
    byte_done = scl_fall && (st_ff.bcnt == `BITS_PER_BYTE);
    next_rd_byte = byte_at(st_ff.regs, st_ff.ptr);

    // drive changes wait out the hold time after scl falls
    if (scl_fall) begin
      nxt_st.hold = `HOLD_W'(`SDA_HOLD_CYC);
    end else if (st_ff.hold != '0) begin
      nxt_st.hold = st_ff.hold - `HOLD_W'(1);
    end
    if (st_ff.hold == `HOLD_W'(1)) begin
      nxt_st.drv = st_ff.pend;
    end

    if (stop_seen) begin
      nxt_st.state = S_IDLE;
      nxt_st.pend = 1'b0;
      nxt_st.drv = 1'b0;
      nxt_st.hold = '0;
    end else if (start_seen) begin
      // a repeated start restarts the address phase but keeps the index
      nxt_st.state = S_ADDR;
      nxt_st.bcnt = '0;
      nxt_st.pend = 1'b0;
      nxt_st.drv = 1'b0;
      nxt_st.hold = '0;
    end else begin
      unique case (st_ff.state)
        S_IDLE, S_IGNORE: begin
          nxt_st.pend = 1'b0;
        end
        S_ADDR, S_INDEX, S_COUNT, S_WDATA: begin
          if (scl_rise) begin
            nxt_st.sh = {st_ff.sh[6:0], nxt_st.sda_f};
            nxt_st.bcnt = st_ff.bcnt + `BIT_CNT_W'(1);
          end
          if (byte_done) begin
            nxt_st.bcnt = '0;
            unique case (st_ff.state)
              S_ADDR: begin
                if (st_ff.sh[7:1] == dev_addr(st_ff.regs[`GEN_CTRL_IDX])) begin
                  nxt_st.pend = 1'b1;
                  nxt_st.rd = st_ff.sh[0];
                  nxt_st.state = S_ACK_A;
                end else begin
                  nxt_st.state = S_IGNORE;
                end
              end
              S_INDEX: begin
                nxt_st.pend = 1'b1;
                nxt_st.ptr = st_ff.sh;
                nxt_st.state = S_ACK_I;
              end
              S_COUNT: begin
                nxt_st.pend = 1'b1;
                nxt_st.rem = st_ff.sh;
                nxt_st.state = S_ACK_C;
              end
              default: begin
                // bytes beyond the announced count are refused
                if (st_ff.rem != 8'h00) begin
                  nxt_st.pend = 1'b1;
                  nxt_st.regs[st_ff.ptr[`REG_IDX_W-1:0]] = st_ff.sh;
                  nxt_st.wr_stb = 1'b1;
                  nxt_st.wr_idx = st_ff.ptr[`REG_IDX_W-1:0];
                  nxt_st.wr_data = st_ff.sh;
                  nxt_st.ptr = st_ff.ptr + 8'h01;
                  nxt_st.rem = st_ff.rem - 8'h01;
                  nxt_st.state = S_ACK_W;
                end else begin
                  nxt_st.state = S_IGNORE;
                end
              end
            endcase
          end
        end
        S_ACK_A: begin
          if (scl_fall) begin
            if (st_ff.rd) begin
              // the count goes first; the index is not advanced by it
              nxt_st.pend = ~st_ff.regs[`RD_COUNT_IDX][7];
              nxt_st.sh = {st_ff.regs[`RD_COUNT_IDX][6:0], 1'b0};
              nxt_st.bcnt = `BIT_CNT_W'(1);
              nxt_st.state = S_TX;
            end else begin
              nxt_st.pend = 1'b0;
              nxt_st.state = S_INDEX;
            end
          end
        end
        S_ACK_I: begin
          if (scl_fall) begin
            nxt_st.pend = 1'b0;
            nxt_st.state = S_COUNT;
          end
        end
        S_ACK_C, S_ACK_W: begin
          if (scl_fall) begin
            nxt_st.pend = 1'b0;
            nxt_st.state = S_WDATA;
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (st_ff.bcnt == `BITS_PER_BYTE) begin
              nxt_st.pend = 1'b0;
              nxt_st.bcnt = '0;
              nxt_st.state = S_RX_ACK;
            end else begin
              nxt_st.pend = ~st_ff.sh[7];
              nxt_st.sh = {st_ff.sh[6:0], 1'b0};
              nxt_st.bcnt = st_ff.bcnt + `BIT_CNT_W'(1);
            end
          end
        end
        S_RX_ACK: begin
          if (scl_rise) begin
            nxt_st.acked = ~nxt_st.sda_f;
          end
          if (scl_fall) begin
            if (st_ff.acked) begin
              nxt_st.pend = ~next_rd_byte[7];
              nxt_st.sh = {next_rd_byte[6:0], 1'b0};
              nxt_st.bcnt = `BIT_CNT_W'(1);
              nxt_st.ptr = st_ff.ptr + 8'h01;
              nxt_st.state = S_TX;
            end else begin
              nxt_st.pend = 1'b0;
              nxt_st.state = S_IGNORE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.scl_s1 <= 1'b1;
      st_ff.scl_s2 <= 1'b1;
      st_ff.scl_s3 <= 1'b1;
      st_ff.sda_s1 <= 1'b1;
      st_ff.sda_s2 <= 1'b1;
      st_ff.sda_s3 <= 1'b1;
      st_ff.scl_f <= 1'b1;
      st_ff.sda_f <= 1'b1;
      st_ff.state <= S_IDLE;
      st_ff.regs <= `REG_BYTES_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // open-drain: the pin is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe = st_ff.drv;
  assign cfg_bytes = st_ff.regs;
  assign xfer_busy = (st_ff.state != S_IDLE) && (st_ff.state != S_IGNORE);
  assign reg_wr_stb = st_ff.wr_stb;
  assign reg_wr_idx = st_ff.wr_idx;
  assign reg_wr_data = st_ff.wr_data;

endmodule

// [logic/i2c_index_pkg.sv]
`include "i2c_index_regs.svh"

package i2c_index_pkg;

  typedef enum logic [11:0] {
    S_IDLE   = 12'h001,
    S_ADDR   = 12'h002,
    S_ACK_A  = 12'h004,
    S_INDEX  = 12'h008,
    S_ACK_I  = 12'h010,
    S_COUNT  = 12'h020,
    S_ACK_C  = 12'h040,
    S_WDATA  = 12'h080,
    S_ACK_W  = 12'h100,
    S_TX     = 12'h200,
    S_RX_ACK = 12'h400,
    S_IGNORE = 12'h800
  } tgt_state_e;

  typedef logic [`REG_COUNT-1:0][7:0] reg_bytes_t;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic scl_f;
    logic sda_f;
    tgt_state_e state;
    logic [7:0] sh;
    logic [`BIT_CNT_W-1:0] bcnt;
    logic [7:0] ptr;
    logic [7:0] rem;
    logic rd;
    logic acked;
    logic pend;
    logic drv;
    logic [`HOLD_W-1:0] hold;
    logic wr_stb;
    logic [`REG_IDX_W-1:0] wr_idx;
    logic [7:0] wr_data;
    reg_bytes_t regs;
  } tgt_s;

endpackage

// [logic/i2c_index_regs.svh]
`ifndef I2C_INDEX_REGS_SVH
`define I2C_INDEX_REGS_SVH

// configuration byte store
`define REG_COUNT 16
`define REG_IDX_W 4
`define REG_BYTES_RST 128'h0000000000000010006C11E01A000000

// byte 0 holds the two-bit bus address select field
`define GEN_CTRL_IDX 4'h0
`define ADDR_SEL_HI 6
`define ADDR_SEL_LO 5
// 7-bit form of write address D0; D2, D4, D6 follow in steps of one
`define DEV_ADDR_BASE 7'h68

// byte returned as the read count
`define RD_COUNT_IDX 4'h8

// bus clock figures
`define SCL_TYP_KHZ 100
`define SCL_MAX_KHZ 400

// internal sda hold after scl falls
`define CLK_PERIOD_PS 8000
`define SDA_HOLD_NS 300
`define SDA_HOLD_CYC ((`SDA_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HOLD_W 6

`define BIT_CNT_W 4
`define BITS_PER_BYTE 4'h8

`endif

// [verification/i2c_ctrl_model.sv]
`timescale 1ns/10ps
module i2c_ctrl_model(
  input wire logic clk,
  input wire logic sda_in,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // quarter bit of 80 clk gives about 390 kHz, inside the rate limit
  task automatic q();
    repeat (80) @(posedge clk);
    #1;
  endtask
  // also serves as repeated start: sda is released in the same step as scl rises
  task automatic start();
    q();
    sda_pull = 1'b0;
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_pull = !b;
    q();
    scl = 1'b1;
    q();
    r = sda_in;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule

// [verification/i2c_index_block_target_tb.sv]
`timescale 1ns/10ps
`include "i2c_index_regs.svh"
module i2c_index_block_target_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, pull, sda_o, sda_oe, busy, stb;
  logic [`REG_COUNT*8-1:0] cfg;
  logic [`REG_IDX_W-1:0] widx;
  logic [7:0] wdat, d;
  logic [7:0] exp_rd [3] = '{8'hA5, 8'h3C, 8'h96};
  wire sda = !(pull | sda_oe);
  int err_total = 0;
  int compares = 0;
  int stores = 0;
  always #4 clk = ~clk;
  // counts store strobes; the strobe lasts one cycle, so each is seen once
  always @(posedge clk) if (stb === 1'b1) stores++;
  i2c_index_block_target u_dut(.clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .cfg_bytes(cfg), .xfer_busy(busy), .reg_wr_stb(stb), .reg_wr_idx(widx),
    .reg_wr_data(wdat));
  i2c_ctrl_model u_host(.clk(clk), .sda_in(sda), .scl(scl), .sda_pull(pull));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] v, input logic e);
    logic a;
    u_host.wbyte(v, a);
    chk("ack", {7'h00, e}, {7'h00, a});
  endtask
  // index 14 with three bytes wraps round to byte 0; a fourth byte is refused
  task automatic t_write();
    u_host.start();
    wb(8'hD0, 1'b1);
    wb(8'h0E, 1'b1);
    wb(8'h03, 1'b1);
    for (int i = 0; i < 3; i++) wb(exp_rd[i], 1'b1);
    wb(8'h77, 1'b0);
    u_host.stop();
    chk("b14", 8'hA5, cfg[14*8 +: 8]);
    chk("b15", 8'h3C, cfg[15*8 +: 8]);
    chk("b0", 8'h96, cfg[7:0]);
    chk("stores", 8'h03, stores[7:0]);
    chk("st idx", 8'h00, {4'h0, widx});
    chk("st data", 8'h96, wdat);
    $display("write test done");
  endtask
  task automatic t_read();
    u_host.start();
    wb(8'hD0, 1'b1);
    wb(8'h0E, 1'b1);
    u_host.start();
    wb(8'hD1, 1'b1);
    u_host.rbyte(1'b0, d);
    chk("count", 8'h10, d);
    for (int i = 0; i < 3; i++) begin
      u_host.rbyte(i == 2, d);
      chk("rdata", exp_rd[i], d);
    end
    u_host.stop();
    repeat (16) @(posedge clk);
    chk("release", 8'h00, {6'h00, sda_oe, busy});
    $display("read test done");
  endtask
  task automatic t_addr();
    u_host.start();
    wb(8'hD2, 1'b0);
    wb(8'h00, 1'b0);
    wb(8'hFF, 1'b0);
    u_host.stop();
    chk("b0", 8'h96, cfg[7:0]);
    u_host.start();
    wb(8'hD0, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h40, 1'b1);
    u_host.stop();
    u_host.start();
    wb(8'hD0, 1'b0);
    u_host.stop();
    u_host.start();
    wb(8'hD4, 1'b1);
    u_host.stop();
    $display("address test done");
  endtask
  // a mid-run reset restores the byte image, so the address goes back to D0
  task automatic t_reset();
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("b0 rst", 8'h00, cfg[7:0]);
    chk("b14 rst", 8'h00, cfg[14*8 +: 8]);
    chk("b8 rst", 8'h10, cfg[8*8 +: 8]);
    chk("idle rst", 8'h00, {6'h00, sda_oe, busy});
    rst_b = 1'b1;
    repeat (8) @(posedge clk);
    u_host.start();
    wb(8'hD0, 1'b1);
    u_host.stop();
    $display("reset test done");
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (8) @(posedge clk);
    chk("b8 reset", 8'h10, cfg[8*8 +: 8]);
    t_write();
    t_read();
    t_addr();
    t_reset();
    wrap_up();
  end
  // about 25 bytes of 2880 clk each fit well inside this span
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule
bind i2c_index_block_target i2c_index_props u_props(.clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .cfg_bytes(cfg_bytes), .xfer_busy(xfer_busy), .reg_wr_stb(reg_wr_stb),
  .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data));

// [verification/i2c_index_props.sv]
`timescale 1ns/10ps
`include "i2c_index_regs.svh"
module i2c_index_props(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [`REG_COUNT*8-1:0] cfg_bytes,
  input wire logic xfer_busy,
  input wire logic reg_wr_stb,
  input wire logic [`REG_IDX_W-1:0] reg_wr_idx,
  input wire logic [7:0] reg_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // the pin may only be pulled low, and only while xfer_busy is high (from the address phase on)
  property p_od; sda_oe |-> (sda_o == 1'b0) && xfer_busy; endproperty
  a_od: assert property (p_od) else $error("sda pulled outside a transfer");
  // device output must not move for 8 clk cycles after scl falls
  property p_hold; $fell(scl_i) |=> $stable(sda_oe) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("sda moved too soon after scl fall");
  property p_rise_low; $rose(sda_oe) |-> !scl_i; endproperty
  a_rise_low: assert property (p_rise_low) else $error("sda pulled while scl high");
  property p_stb_busy; reg_wr_stb |-> xfer_busy; endproperty
  a_stb_busy: assert property (p_stb_busy) else $error("store outside transfer");
  property p_pulse; reg_wr_stb |=> !reg_wr_stb; endproperty
  a_pulse: assert property (p_pulse) else $error("store strobe too long");
  property p_store; reg_wr_stb |-> cfg_bytes[reg_wr_idx*8 +: 8] == reg_wr_data; endproperty
  a_store: assert property (p_store) else $error("stored byte mismatch");
  property p_quiet; $changed(cfg_bytes) |-> reg_wr_stb; endproperty
  a_quiet: assert property (p_quiet) else $error("config changed without store");
  property p_stop; scl_i && $rose(sda_i) |-> ##[1:12] (!xfer_busy && !sda_oe); endproperty
  a_stop: assert property (p_stop) else $error("not released after stop");
endmodule
